// [rtl/i2c_pkg.sv]
// Shared constants and types for the two-wire slave and its bus master.
// Assumes a single 250 MHz clock and active-low asynchronous reset at both ends.
package i2c_pkg;
	// Slave side
	localparam logic [6:0] DEV_ADDR         = 7'h68;
	localparam logic [7:0] REG_FILTER_CTRL  = 8'h0E;
	localparam logic [7:0] REG_TIMEOUT_CTRL = 8'h10;
	localparam int         TO_EN_BIT        = 7;
	localparam int         TO_FLAG_BIT      = 6;
	localparam int         TO_PER_MSB       = 5;
	localparam int         FILT_MSB         = 3;
	localparam int         FILT_LSB         = 2;
	localparam logic [7:0] TO_CTRL_RESET    = 8'h00;
	localparam logic [1:0] FILT_SEL_RESET   = 2'h0;
	localparam int         SUB_DIV          = 128;
	localparam int         TO_CLK_DIV       = 32;
	localparam int         TO_TICK_CYCLES   = SUB_DIV * TO_CLK_DIV;
	localparam int         FIFO_DEPTH       = 16;
	localparam int         FIFO_WIDTH       = 16;

	// Master side software registers
	localparam logic [7:0] H_CMD            = 8'h00;
	localparam logic [7:0] H_TXDATA         = 8'h04;
	localparam logic [7:0] H_RXDATA         = 8'h08;
	localparam logic [7:0] H_STATUS         = 8'h0C;
	localparam logic [7:0] H_DIV            = 8'h10;
	localparam logic [7:0] H_DIV_RESET      = 8'hF9;
	localparam int         CMD_START        = 0;
	localparam int         CMD_STOP         = 1;
	localparam int         CMD_WRITE        = 2;
	localparam int         CMD_READ         = 3;
	localparam int         CMD_NACK         = 4;

	typedef enum logic [2:0] {D_IDLE, D_ADDR, D_REG, D_WR, D_RD} dev_state_t;
	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_t;
endpackage

// [rtl/i2c_link_if.sv]
// Open-drain two-wire bus joining the master and the slave.
// Assumes each end drives a line low only while its enable is high.
`timescale 1ns/1ps
interface i2c_link_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;
	logic scl;
	logic sda;

	// Wired-AND with pull-ups
	assign scl = ~(m_scl_oe & ~m_scl_o);
	assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

	modport dev  (input scl, input sda, output s_sda_o, output s_sda_oe);
	modport host (input sda, output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe);
endinterface

// [rtl/i2c_slave.sv]
// Two-wire slave with bus timeout, input filter and a write FIFO.
// Assumes the master owns the clock line and never stretches; one clock.
//
// Operation
// - Only the master generates start conditions
// - Start: data falls while clock high
// - Master sends address first after start
// - Acknowledge own address on ninth clock
// - Master stops after unacknowledged address
// - Data bytes only after address acknowledge
// - Bytes shift most significant bit first
// - Receiver drives low acknowledge per byte; the slave leaves a written data byte unacknowledged while the FIFO is full
// - Release data line on master nack
// - Control holds enable bit 7, period
// - Timeout sets flag bit 6
// - Flag clears only by software zero write
// - Timeout is (period+1) times 32 sub clocks
// - Slave never drives the clock line
// - Fixed slave address
// - Filter select: none, 2 or 4 clocks
`timescale 1ns/1ps
module sync_fifo #(
	parameter int W = 16,
	parameter int D = 16
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);

	initial
	begin
		if (D < 2 || (1 << AW) != D) $error("sync_fifo depth must be a power of two");
	end

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} fifo_reg_t;

	fifo_reg_t      r_r;
	fifo_reg_t      r_nxt;
	logic [W-1:0]   mem [D];
	logic           push;
	logic           pop;

	assign in_ready  = (r_r.cnt != (AW+1)'(D));
	assign out_valid = (r_r.cnt != '0);
	assign out_data  = mem[r_r.rp];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb
	begin
		r_nxt = r_r;
		if (push) r_nxt.wp = r_r.wp + 1'b1;
		if (pop) r_nxt.rp = r_r.rp + 1'b1;
		r_nxt.cnt = r_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n) r_r <= '0;
		else r_r <= r_nxt;
	end

	always_ff @(posedge clk)
	begin
		if (push) mem[r_r.wp] <= in_data;
	end
endmodule // sync_fifo

module i2c_slave
	import i2c_pkg::*;
#(
	parameter int TICK_CYCLES = i2c_pkg::TO_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic  clk,
	input  wire logic  rst_n,
	// Bus
	i2c_link_if.dev    link,
	// Written bytes, {register, data}
	output logic       wr_valid,
	input  wire logic  wr_ready,
	output logic [15:0] wr_data,
	// Read source for other registers
	output logic [7:0] rd_addr,
	input  wire logic [7:0] rd_data,
	// Status
	output logic       timeout_flag
);
	import i2c_pkg::*;

	localparam int PW = $clog2(TICK_CYCLES);

	initial
	begin
		if (TICK_CYCLES < 2) $error("i2c_slave tick must be at least two cycles");
	end

	typedef struct packed {
		logic [1:0]      s1;
		logic [1:0]      s2;
		logic [1:0]      filt;
		logic [1:0]      prev;
		logic [1:0][2:0] fcnt;
		dev_state_t      st;
		logic [3:0]      bitc;
		logic [7:0]      sh;
		logic [7:0]      ptr;
		logic            ack_ok;
		logic            sda_oe;
		logic [7:0]      toc;
		logic [1:0]      fsel;
		logic [PW-1:0]   pre;
		logic [5:0]      tcnt;
	} dev_reg_t;

	dev_reg_t  r_r;
	dev_reg_t  r_nxt;
	logic      push;
	logic      push_ready;
	logic [1:0] pins;

	function automatic logic [2:0] filt_len(input logic [1:0] sel);
		case (sel)
			2'h0:    filt_len = 3'h0;
			2'h1:    filt_len = 3'h2;
			default: filt_len = 3'h4;
		endcase
	endfunction

	function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [7:0] toc,
			input logic [1:0] fsel, input logic [7:0] ext);
		if (a == REG_TIMEOUT_CTRL) rd_byte = toc;
		else if (a == REG_FILTER_CTRL) rd_byte = {4'h0, fsel, 2'h0};
		else rd_byte = ext;
	endfunction

	assign pins = {link.sda, link.scl};

	always_comb
	begin
		logic scl;
		logic sda;
		logic rise;
		logic fall;
		logic start;
		logic stop;
		logic tmo;
		logic [7:0] b;
		scl = 1'b0;
		sda = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		start = 1'b0;
		stop = 1'b0;
		tmo = 1'b0;
		b = 8'h00;
		r_nxt = r_r;
		push = 1'b0;
		// Synchronise, then filter each line
		for (int i = 0; i < 2; i++)
		begin
			r_nxt.s1[i] = pins[i];
			r_nxt.s2[i] = r_r.s1[i];
			if (r_r.s2[i] == r_r.filt[i]) r_nxt.fcnt[i] = 3'h0;
			else if (r_r.fcnt[i] + 3'h1 >= filt_len(r_r.fsel))
			begin
				r_nxt.filt[i] = r_r.s2[i];
				r_nxt.fcnt[i] = 3'h0;
			end
			else r_nxt.fcnt[i] = r_r.fcnt[i] + 3'h1;
		end
		r_nxt.prev = r_r.filt;
		scl = r_r.filt[0];
		sda = r_r.filt[1];
		rise = scl & ~r_r.prev[0];
		fall = ~scl & r_r.prev[0];
		start = scl & r_r.prev[0] & r_r.prev[1] & ~sda;
		stop = scl & r_r.prev[0] & ~r_r.prev[1] & sda;
		// Timeout: counts only while a transfer stalls
		if (!r_r.toc[TO_EN_BIT] || r_r.st == D_IDLE || rise || fall)
		begin
			r_nxt.pre = '0;
			r_nxt.tcnt = 6'h00;
		end
		else if (r_r.pre == PW'(TICK_CYCLES - 1))
		begin
			r_nxt.pre = '0;
			if (r_r.tcnt == r_r.toc[TO_PER_MSB:0])
			begin
				tmo = 1'b1;
				r_nxt.tcnt = 6'h00;
			end
			else r_nxt.tcnt = r_r.tcnt + 6'h01;
		end
		else r_nxt.pre = r_r.pre + 1'b1;
		// Byte engine
		if (tmo)
		begin
			r_nxt.st = D_IDLE;
			r_nxt.sda_oe = 1'b0;
		end
		else if (start)
		begin
			r_nxt.st = D_ADDR;
			r_nxt.bitc = 4'h0;
			r_nxt.sda_oe = 1'b0;
		end
		else if (stop)
		begin
			r_nxt.st = D_IDLE;
			r_nxt.sda_oe = 1'b0;
		end
		else if (r_r.st != D_IDLE && rise)
		begin
			if (r_r.bitc < 4'h8 && r_r.st != D_RD) r_nxt.sh = {r_r.sh[6:0], sda};
			if (r_r.bitc == 4'h8 && r_r.st == D_RD) r_nxt.ack_ok = ~sda;
			r_nxt.bitc = r_r.bitc + 4'h1;
		end
		else if (r_r.st != D_IDLE && fall)
		begin
			if (r_r.bitc == 4'h8)
			begin
				case (r_r.st)
					D_ADDR: r_nxt.ack_ok = (r_r.sh[7:1] == DEV_ADDR);
					D_REG:
					begin
						r_nxt.ack_ok = 1'b1;
						r_nxt.ptr = r_r.sh;
					end
					D_WR:
					begin
						r_nxt.ack_ok = 1'b1;
						if (r_r.ptr == REG_TIMEOUT_CTRL)
							r_nxt.toc = {r_r.sh[7], r_r.toc[6] & r_r.sh[6], r_r.sh[5:0]};
						else if (r_r.ptr == REG_FILTER_CTRL)
							r_nxt.fsel = r_r.sh[FILT_MSB:FILT_LSB];
						else
						begin
							push = push_ready;
							r_nxt.ack_ok = push_ready;
						end
					end
					default: r_nxt.ack_ok = r_r.ack_ok;
				endcase
				r_nxt.sda_oe = (r_r.st != D_RD) && r_nxt.ack_ok;
			end
			else if (r_r.bitc == 4'h9)
			begin
				r_nxt.bitc = 4'h0;
				r_nxt.sda_oe = 1'b0;
				b = rd_byte(r_r.ptr, r_r.toc, r_r.fsel, rd_data);
				case (r_r.st)
					D_ADDR:
					begin
						if (!r_r.ack_ok) r_nxt.st = D_IDLE;
						else if (r_r.sh[0]) r_nxt.st = D_RD;
						else r_nxt.st = D_REG;
					end
					D_REG: r_nxt.st = D_WR;
					D_RD:
					begin
						if (!r_r.ack_ok) r_nxt.st = D_IDLE;
					end
					default: r_nxt.st = r_r.st;
				endcase
				if (r_nxt.st == D_RD)
				begin
					r_nxt.sh = b;
					r_nxt.sda_oe = ~b[7];
				end
			end
			else if (r_r.st == D_RD && r_r.bitc != 4'h0)
			begin
				r_nxt.sh = {r_r.sh[6:0], 1'b0};
				r_nxt.sda_oe = ~r_r.sh[6];
			end
		end
		if (tmo) r_nxt.toc[TO_FLAG_BIT] = 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r_r <= '0;
			r_r.s1 <= 2'h3;
			r_r.s2 <= 2'h3;
			r_r.filt <= 2'h3;
			r_r.prev <= 2'h3;
			r_r.st <= D_IDLE;
			r_r.toc <= TO_CTRL_RESET;
			r_r.fsel <= FILT_SEL_RESET;
		end
		else r_r <= r_nxt;
	end

	sync_fifo #(
		.W (FIFO_WIDTH),
		.D (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (push),
		.in_ready  (push_ready),
		.in_data   ({r_r.ptr, r_r.sh}),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  (wr_data)
	);

	assign link.s_sda_o  = 1'b0;
	assign link.s_sda_oe = r_r.sda_oe;
	assign rd_addr       = r_r.ptr;
	assign timeout_flag  = r_r.toc[TO_FLAG_BIT];
endmodule // i2c_slave

// [rtl/i2c_master.sv]
// Two-wire bus master driven by software through a small register port.
// Assumes the slave never stretches the clock; one clock domain.
`timescale 1ns/1ps
module i2c_master
	import i2c_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Bus
	i2c_link_if.host        link,
	// Software port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata
);
	import i2c_pkg::*;

	typedef struct packed {
		logic        s1;
		logic        s2;
		host_state_t st;
		logic [1:0]  ph;
		logic [7:0]  cnt;
		logic [7:0]  divr;
		logic [3:0]  bitc;
		logic [8:0]  tx;
		logic [8:0]  rx;
		logic [7:0]  txd;
		logic        nack;
		logic        first;
		logic        wrop;
		logic        scl_oe;
		logic        sda_oe;
		logic [7:0]  rdata;
	} host_reg_t;

	host_reg_t r_r;
	host_reg_t r_nxt;

	always_comb
	begin
		logic tick;
		tick = (r_r.cnt == r_r.divr);
		r_nxt = r_r;
		r_nxt.s1 = link.sda;
		r_nxt.s2 = r_r.s1;
		r_nxt.cnt = (tick || r_r.st == H_IDLE) ? 8'h00 : r_r.cnt + 8'h01;
		// Software port
		case (reg_addr)
			H_STATUS: r_nxt.rdata = {6'h00, r_r.nack, r_r.st != H_IDLE};
			H_RXDATA: r_nxt.rdata = r_r.rx[8:1];
			H_TXDATA: r_nxt.rdata = r_r.txd;
			H_DIV:    r_nxt.rdata = r_r.divr;
			default:  r_nxt.rdata = 8'h00;
		endcase
		if (!reg_rd) r_nxt.rdata = r_r.rdata;
		if (reg_wr && reg_addr == H_TXDATA) r_nxt.txd = reg_wdata;
		if (reg_wr && reg_addr == H_DIV) r_nxt.divr = reg_wdata;
		if (reg_wr && reg_addr == H_CMD && r_r.st == H_IDLE)
		begin
			r_nxt.ph = 2'h0;
			r_nxt.bitc = 4'h0;
			if (reg_wdata[CMD_START]) r_nxt.st = H_START;
			else if (reg_wdata[CMD_STOP]) r_nxt.st = H_STOP;
			else if (reg_wdata[CMD_WRITE])
			begin
				r_nxt.st = H_BIT;
				r_nxt.wrop = 1'b1;
				r_nxt.tx = {r_r.txd, 1'b1};
			end
			else if (reg_wdata[CMD_READ])
			begin
				r_nxt.st = H_BIT;
				r_nxt.wrop = 1'b0;
				r_nxt.tx = {8'hFF, reg_wdata[CMD_NACK]};
			end
		end
		// Bus sequencer, four phases per step
		if (tick && r_r.st != H_IDLE)
		begin
			r_nxt.ph = r_r.ph + 2'h1;
			case (r_r.st)
				H_START:
				begin
					case (r_r.ph)
						2'h0: r_nxt.sda_oe = 1'b0;
						2'h1: r_nxt.scl_oe = 1'b0;
						2'h2: r_nxt.sda_oe = 1'b1;
						default:
						begin
							r_nxt.scl_oe = 1'b1;
							r_nxt.first = 1'b1;
							r_nxt.st = H_IDLE;
						end
					endcase
				end
				H_BIT:
				begin
					case (r_r.ph)
						2'h0: r_nxt.sda_oe = ~r_r.tx[8];
						2'h1: r_nxt.scl_oe = 1'b0;
						2'h2: r_nxt.rx = {r_r.rx[7:0], r_r.s2};
						default:
						begin
							r_nxt.scl_oe = 1'b1;
							r_nxt.tx = {r_r.tx[7:0], 1'b1};
							r_nxt.bitc = r_r.bitc + 4'h1;
							if (r_r.bitc == 4'h8)
							begin
								r_nxt.sda_oe = 1'b0;
								r_nxt.nack = r_r.rx[0];
								r_nxt.first = 1'b0;
								r_nxt.st = (r_r.first && r_r.wrop && r_r.rx[0]) ? H_STOP : H_IDLE;
							end
						end
					endcase
				end
				H_STOP:
				begin
					case (r_r.ph)
						2'h0: r_nxt.sda_oe = 1'b1;
						2'h1: r_nxt.scl_oe = 1'b0;
						2'h2: r_nxt.sda_oe = 1'b0;
						default: r_nxt.st = H_IDLE;
					endcase
				end
				default: r_nxt.st = H_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r_r <= '0;
			r_r.s1 <= 1'b1;
			r_r.s2 <= 1'b1;
			r_r.st <= H_IDLE;
			r_r.divr <= H_DIV_RESET;
		end
		else r_r <= r_nxt;
	end

	assign link.m_scl_o  = 1'b0;
	assign link.m_scl_oe = r_r.scl_oe;
	assign link.m_sda_o  = 1'b0;
	assign link.m_sda_oe = r_r.sda_oe;
	assign reg_rdata     = r_r.rdata;
endmodule // i2c_master

// [bench/i2c_slave_checker.sv]
// Checker for the two-wire link between master and slave.
// Assumes one clock; watches the resolved lines and the slave flag.
`timescale 1ns/1ps
module i2c_slave_checker
	import i2c_pkg::*;
#(
	parameter int TICK = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Bus
	input wire logic m_sda_oe,
	input wire logic s_sda_oe,
	input wire logic scl,
	input wire logic sda,
	// Status
	input wire logic timeout_flag
);
	logic       scl_r, sda_r, first_r, rdm_r, aok_r, nak_r, rise, strt;
	logic [3:0] bit_r;
	logic [7:0] sh_r;
	logic [9:0] stall_r;
	assign rise = scl & ~scl_r;
	assign strt = scl & scl_r & sda_r & ~sda;
	// Bit position, address match and direction of the transfer
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{scl_r, sda_r, first_r, rdm_r, aok_r, nak_r} <= 6'h30;
			{bit_r, sh_r, stall_r} <= 22'h000000;
		end
		else
		begin
			scl_r <= scl;
			sda_r <= sda;
			stall_r <= (scl != scl_r) ? 10'h000 : stall_r + {9'h000, stall_r != 10'h3FF};
			if (strt)
			begin
				bit_r <= 4'h0;
				first_r <= 1'b1;
				nak_r <= 1'b0;
			end
			else if (rise)
			begin
				sh_r <= {sh_r[6:0], sda};
				bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
				if (bit_r == 4'h8)
				begin
					first_r <= 1'b0;
					nak_r <= nak_r | (!first_r & rdm_r & aok_r & sda);
				end
				if (bit_r == 4'h8 && first_r)
				begin
					aok_r <= sh_r[7:1] == DEV_ADDR;
					rdm_r <= sh_r[0];
				end
			end
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_start_by_master: assert property (strt |-> m_sda_oe && !s_sda_oe)
		else $error("start not made by master");
	a_ack_own_addr: assert property (rise && bit_r == 4'h8 && first_r |->
		s_sda_oe == (sh_r[7:1] == DEV_ADDR)) else $error("address ack wrong");
	a_data_after_ack: assert property (rise && bit_r < 4'h8 && s_sda_oe |->
		rdm_r && aok_r && !first_r) else $error("data driven without address ack");
	a_ack_stands: assert property ($rose(scl) && s_sda_oe |-> s_sda_oe[*8])
		else $error("slave drive dropped while clock high");
	a_change_scl_low: assert property ($changed(s_sda_oe) |-> !scl)
		else $error("slave data changed while clock high");
	a_release_nack: assert property (nak_r |-> !s_sda_oe)
		else $error("slave drives after master nack");
	a_stall_before_to: assert property ($rose(timeout_flag) |-> stall_r >= TICK)
		else $error("timeout without stall");
	a_to_release: assert property ($rose(timeout_flag) |-> ##[0:3] !s_sda_oe)
		else $error("data line held after timeout");
endmodule // i2c_slave_checker

// [bench/test_i2c_slave_with_bus_timeout.sv]
// Bench: master and slave joined by the link, queue model of the FIFO.
// Assumes one 250 MHz clock and a shortened timeout tick.
`timescale 1ns/1ps
module test_i2c_slave_with_bus_timeout;
	import i2c_pkg::*;
	localparam logic [7:0] C_ST = 8'h01 << CMD_START;
	localparam logic [7:0] C_SP = 8'h01 << CMD_STOP;
	localparam logic [7:0] A_W  = {DEV_ADDR, 1'b0};
	logic        clk = 1'b0, rst_n = 1'b0, wr_ready = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, rd_data = 8'h00, rdv;
	logic        wr_valid, timeout_flag;
	logic [15:0] wr_data;
	logic [7:0]  rd_addr, reg_rdata;
	logic [8:0]  mon = 9'h000;
	logic [15:0] q[$];
	int          bad_count = 0, cmp_count = 0;
	i2c_link_if link();
	i2c_slave #(.TICK_CYCLES(8)) i2c_slave_i (.clk(clk), .rst_n(rst_n), .link(link),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_addr(rd_addr),
		.rd_data(rd_data), .timeout_flag(timeout_flag));
	i2c_master i2c_master_i (.clk(clk), .rst_n(rst_n), .link(link), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	i2c_slave_checker #(.TICK(8)) i2c_slave_checker_i (.clk(clk), .rst_n(rst_n),
		.m_sda_oe(link.m_sda_oe), .s_sda_oe(link.s_sda_oe), .scl(link.scl),
		.sda(link.sda), .timeout_flag(timeout_flag));
	always #2 clk = ~clk;
	// Last nine bits seen on the wire
	always @(posedge link.scl) mon <= {mon[7:0], link.sda};
	task chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("ERROR at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task report_and_stop();
		$display("TB: %0d mismatches in %0d compares", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		rdv = reg_rdata;
	endtask
	// Issue one bus step and wait until the master is idle
	task cmd(input logic [7:0] c);
		int n;
		wr(H_CMD, c);
		rd(H_STATUS);
		for (n = 0; rdv[0] !== 1'b0 && n < 3000; n++)
			rd(H_STATUS);
		if (n == 3000)
			bad_count++;
	endtask
	task xb(input logic [7:0] d, input logic a, input logic st = 1'b0);
		wr(H_TXDATA, d);
		cmd(8'h01 << CMD_WRITE);
		rd(H_STATUS);
		chk(rdv[1], !a);
		chk(mon, st ? {d[6:0], 2'b10} : {d, ~a});
	endtask
	task rb(input logic [7:0] e, input logic l);
		cmd((8'h01 << CMD_READ) | ({7'h00, l} << CMD_NACK));
		rd(H_RXDATA);
		chk(rdv, e);
		chk(mon, {e, l});
	endtask
	task sw(input logic [7:0] r, input logic [7:0] d);
		cmd(C_ST);
		xb(A_W, 1'b1);
		xb(r, 1'b1);
		xb(d, 1'b1);
		cmd(C_SP);
	endtask
	task sr(input logic [7:0] r, input logic [7:0] e, input int n);
		cmd(C_ST);
		xb(A_W, 1'b1);
		xb(r, 1'b1);
		cmd(C_ST);
		xb({DEV_ADDR, 1'b1}, 1'b1);
		for (int k = 0; k < n; k++)
			rb(e, k == n - 1);
		cmd(C_SP);
	endtask
	initial
	begin
		repeat (90000) @(posedge clk);
		bad_count++;
		report_and_stop();
	end
	initial
	begin
		logic [7:0] r;
		logic [7:0] d;
		int s;
		s = $urandom(32'hB7B52A5A);
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk(wr_valid, 1'b0);
		chk(timeout_flag, 1'b0);
		rd(H_DIV);
		chk(rdv, H_DIV_RESET);
		wr(H_DIV, 8'h07);
		sr(REG_TIMEOUT_CTRL, TO_CTRL_RESET, 1);
		for (int i = 0; i < 4; i++)
		begin
			sw(REG_FILTER_CTRL, 8'(i << FILT_LSB));
			sr(REG_FILTER_CTRL, 8'(i << FILT_LSB), 1);
		end
		cmd(C_ST);
		xb(8'hA0, 1'b0, 1'b1);
		sw(REG_TIMEOUT_CTRL, 8'hBF);
		sr(REG_TIMEOUT_CTRL, 8'hBF, 1);
		// Fill the FIFO past full with the drain side stalled
		r = 8'h20 | 8'($urandom_range(31));
		cmd(C_ST);
		xb(A_W, 1'b1);
		xb(r, 1'b1);
		for (int i = 0; i <= FIFO_DEPTH; i++)
		begin
			d = 8'($urandom);
			xb(d, i < FIFO_DEPTH);
			if (i < FIFO_DEPTH)
				q.push_back({r, d});
		end
		cmd(C_SP);
		while (q.size() > 0)
		begin
			repeat ($urandom_range(3)) @(posedge clk);
			@(negedge clk);
			chk(wr_valid, 1'b1);
			chk(wr_data, q.pop_front());
			@(posedge clk) wr_ready <= 1'b1;
			@(posedge clk) wr_ready <= 1'b0;
		end
		@(negedge clk);
		chk(wr_valid, 1'b0);
		d = 8'($urandom_range(127));
		@(posedge clk) rd_data <= d;
		sr(r, d, 2);
		chk(rd_addr, r);
		// Stall inside a read, slave holding the next MSB low; period 63
		cmd(C_ST);
		xb(A_W, 1'b1);
		xb(r, 1'b1);
		cmd(C_ST);
		xb({DEV_ADDR, 1'b1}, 1'b1);
		rb(d, 1'b0);
		repeat (440) @(negedge clk);
		chk(link.sda, 1'b0);
		chk(timeout_flag, 1'b0);
		repeat (100) @(negedge clk);
		chk(timeout_flag, 1'b1);
		chk(link.sda, 1'b1);
		cmd(C_SP);
		sr(REG_TIMEOUT_CTRL, 8'hFF, 1);
		sw(REG_TIMEOUT_CTRL, 8'hFF);
		chk(timeout_flag, 1'b1);
		sw(REG_TIMEOUT_CTRL, 8'h3F);
		sr(REG_TIMEOUT_CTRL, 8'h3F, 1);
		cmd(C_ST);
		xb(A_W, 1'b1);
		repeat (600) @(negedge clk);
		chk(timeout_flag, 1'b0);
		cmd(C_SP);
		report_and_stop();
	end
endmodule // test_i2c_slave_with_bus_timeout
